// ===== verilog/vui_top.sv
// Vectored interrupt unit: requests, masking, priority and entry sequence
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module vui_top #(
	parameter int NREQ = 6
) (
	input wire logic CLK, // Processor clock
	input wire logic RSTN, // Asynchronous reset, low
	input wire logic PSEL, // APB select
	input wire logic PENABLE, // APB access phase
	input wire logic PWRITE, // APB direction
	input wire logic [11:0] PADDR, // APB byte address
	input wire logic [31:0] PWDATA, // APB write data
	output logic [31:0] PRDATA, // APB read data
	output logic PREADY, // APB ready
	output logic PSLVERR, // APB error on unmapped address
	input wire logic [3:0] EXT_REQ_PINS, // External request pins
	input wire logic SER_TX_REQ, // Serial transmitter request
	input wire logic SER_RX_REQ, // Serial receiver request
	input wire logic [1:0] PRESCALE_END, // Counter prescalers at end
	input wire logic [1:0] COUNT_END, // Counters at end
	input wire logic LAST_CYCLE, // Last cycle of an instruction
	input wire logic [15:0] PC_IN, // Program counter to save
	input wire logic [7:0] FLAGS_IN, // Flag register to save
	input wire logic [7:0] VEC_DATA, // Vector byte, in the cycle of the read strobe
	output vui_pkg::vui_push_t PUSH, // Stack write strobe
	output vui_pkg::vui_fetch_t FETCH, // Vector read strobe
	output logic JUMP, // Pulse: load NEW_PC
	output logic [15:0] NEW_PC, // Service routine start
	output logic BUSY, // Entry sequence running
	output logic INT_LINE // Unmasked status event pending
);
	// Elaboration check
	if (NREQ != 6) begin : g_bad
		$error("vui_top serves exactly six requests");
	end

	logic rst_q1;
	logic rst_n;
	logic [NREQ-1:0] req;
	logic [7:0] mask;
	logic [3:0] prio;
	logic [1:0] ctrl;
	logic [1:0] evt;
	logic [1:0] evt_mask;
	logic [7:0] stack_pointer_high;
	logic [7:0] spl;
	logic [NREQ-1:0] src;
	logic [NREQ-1:0] src_prev;
	logic [NREQ-1:0] src_rise;
	logic [NREQ-1:0] eligible;
	vui_pkg::vui_state_t state;
	vui_pkg::vui_state_t next_state;
	logic [5:0] cnt;
	logic [2:0] grant;
	logic [2:0] next_grant;
	logic found;
	logic take;
	logic wr;
	logic rd;
	logic [9:0] idx;
	logic mapped;
	logic [15:0] vec;
	logic fetch_hi_q;
	logic fetch_lo_q;
	logic push_now;
	logic [7:0] push_byte;
	logic [15:0] sp_dec;
	logic [7:0] spl_dec;
	logic push_fault;
	logic entry_done;

	// Reset release through two flip-flops
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// Source to request mapping
	always_comb begin
		src[0] = EXT_REQ_PINS[2];
		src[1] = EXT_REQ_PINS[3];
		src[2] = EXT_REQ_PINS[1];
		src[3] = EXT_REQ_PINS[0] | SER_RX_REQ;
		src[4] = (PRESCALE_END[0] & COUNT_END[0]) | SER_TX_REQ;
		src[5] = PRESCALE_END[1] & COUNT_END[1];
	end

	// Source edge memory
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			src_prev <= '0;
		end else begin
			src_prev <= src;
		end
	end
	assign src_rise = src & ~src_prev;

	// APB decode
	assign idx = PADDR[11:2];
	assign wr = PSEL & PENABLE & PWRITE & ~PREADY;
	assign rd = PSEL & PENABLE & ~PWRITE & ~PREADY;
	always_comb begin
		case (idx)
			vui_pkg::IDX_REQ, vui_pkg::IDX_MASK, vui_pkg::IDX_PRIO,
			vui_pkg::IDX_CTRL, vui_pkg::IDX_EVT, vui_pkg::IDX_EVT_MASK,
			vui_pkg::IDX_STATE, vui_pkg::IDX_SPH, vui_pkg::IDX_SPL: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// APB answer, one wait state
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h00000000;
		end else begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
			PRDATA <= 32'h00000000;
			if (rd) begin
				case (idx)
					vui_pkg::IDX_REQ: PRDATA <= {26'h0, req};
					vui_pkg::IDX_MASK: PRDATA <= {24'h0, mask};
					vui_pkg::IDX_PRIO: PRDATA <= {28'h0, prio};
					vui_pkg::IDX_CTRL: PRDATA <= {30'h0, ctrl};
					vui_pkg::IDX_EVT: PRDATA <= {30'h0, evt};
					vui_pkg::IDX_EVT_MASK: PRDATA <= {30'h0, evt_mask};
					vui_pkg::IDX_STATE: PRDATA <= {27'h0, BUSY, 1'b0, grant};
					vui_pkg::IDX_SPH: PRDATA <= {24'h0, stack_pointer_high};
					vui_pkg::IDX_SPL: PRDATA <= {24'h0, spl};
					default: PRDATA <= 32'h00000000;
				endcase
			end
		end
	end

	// Request register: hardware set wins over any clear
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			req <= '0;
		end else begin
			logic [NREQ-1:0] nxt;
			nxt = req;
			if (wr && idx == vui_pkg::IDX_REQ) begin
				nxt = PWDATA[NREQ-1:0];
			end
			if (state == vui_pkg::VUI_PUSH && cnt == vui_pkg::PUSH_LAST) begin
				nxt[grant] = 1'b0;
			end
			req <= nxt | src_rise;
		end
	end

	// Setup age per request; eligible after five periods
	for (genvar i = 0; i < NREQ; i++) begin : g_age
		logic [2:0] age;
		always_ff @(posedge CLK or negedge rst_n) begin
			if (!rst_n) begin
				age <= 3'd0;
			end else if (!req[i]) begin
				age <= 3'd0;
			end else if (age != 3'(vui_pkg::REQ_SETUP_PERIODS)) begin
				age <= age + 3'd1;
			end
		end
		assign eligible[i] = req[i] & mask[i] &
			(age == 3'(vui_pkg::REQ_SETUP_PERIODS));
	end

	// Control registers written by software
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			mask <= vui_pkg::MASK_RESET;
			prio <= vui_pkg::PRIO_RESET;
			ctrl <= vui_pkg::CTRL_RESET;
			evt_mask <= 2'b00;
		end else begin
			if (wr && idx == vui_pkg::IDX_MASK) begin
				mask <= {PWDATA[7], 1'b0, PWDATA[NREQ-1:0]};
			end
			if (take) begin
				mask[vui_pkg::MASK_GLOBAL_BIT] <= 1'b0;
			end
			if (wr && idx == vui_pkg::IDX_PRIO) begin
				prio <= PWDATA[3:0];
			end
			if (wr && idx == vui_pkg::IDX_CTRL) begin
				ctrl <= PWDATA[1:0];
			end
			if (wr && idx == vui_pkg::IDX_EVT_MASK) begin
				evt_mask <= PWDATA[1:0];
			end
		end
	end

	// Priority encoder: rotating start, optional reverse order
	always_comb begin
		logic [2:0] k;
		k = 3'd0;
		found = 1'b0;
		next_grant = 3'd0;
		for (int n = 0; n < NREQ; n++) begin
			if (prio[vui_pkg::PRIO_REVERSE_BIT]) begin
				k = 3'((int'(prio[2:0]) + NREQ - n) % NREQ);
			end else begin
				k = 3'((int'(prio[2:0]) + n) % NREQ);
			end
			if (!found && eligible[k]) begin
				found = 1'b1;
				next_grant = k;
			end
		end
	end

	// Grant at the instruction's last cycle
	assign take = (state == vui_pkg::VUI_IDLE) & LAST_CYCLE & found &
		mask[vui_pkg::MASK_GLOBAL_BIT];

	// Entry sequencer next state
	always_comb begin
		case (state)
			vui_pkg::VUI_IDLE: next_state = take ? vui_pkg::VUI_PUSH : vui_pkg::VUI_IDLE;
			vui_pkg::VUI_PUSH: next_state = (cnt == vui_pkg::PUSH_LAST) ?
				vui_pkg::VUI_FETCH : vui_pkg::VUI_PUSH;
			vui_pkg::VUI_FETCH: next_state = (cnt == vui_pkg::FETCH_LAST) ?
				vui_pkg::VUI_JUMP : vui_pkg::VUI_FETCH;
			vui_pkg::VUI_JUMP: next_state = vui_pkg::VUI_IDLE;
			default: next_state = vui_pkg::VUI_IDLE;
		endcase
	end

	// Sequencer state and cycle count from the sample point
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state <= vui_pkg::VUI_IDLE;
			cnt <= 6'd0;
			grant <= 3'd0;
			BUSY <= 1'b0;
		end else begin
			state <= next_state;
			BUSY <= (next_state != vui_pkg::VUI_IDLE);
			if (take) begin
				grant <= next_grant;
				cnt <= 6'd1;
			end else if (state != vui_pkg::VUI_IDLE) begin
				cnt <= cnt + 6'd1;
			end else begin
				cnt <= 6'd0;
			end
		end
	end

	// Push selection: PC low, PC high, then flags
	assign push_now = (state == vui_pkg::VUI_PUSH) && (cnt == vui_pkg::PUSH_PCL_AT ||
		cnt == vui_pkg::PUSH_PCH_AT || cnt == vui_pkg::PUSH_FLG_AT);
	always_comb begin
		if (cnt == vui_pkg::PUSH_PCL_AT) begin
			push_byte = PC_IN[7:0];
		end else if (cnt == vui_pkg::PUSH_PCH_AT) begin
			push_byte = PC_IN[15:8];
		end else begin
			push_byte = FLAGS_IN;
		end
	end
	assign sp_dec = {stack_pointer_high, spl} - 16'd1;
	assign spl_dec = spl - 8'd1;
	always_comb begin
		if (ctrl[vui_pkg::CTRL_EXT_STACK_BIT]) begin
			push_fault = ~ctrl[vui_pkg::CTRL_EXT_PROG_BIT] &
				(sp_dec < vui_pkg::EXT_STACK_FLOOR);
		end else begin
			push_fault = (spl_dec < vui_pkg::INT_STACK_LOW) |
				(spl_dec > vui_pkg::INT_STACK_HIGH);
		end
	end

	// Stack pointer and stack write strobe
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			stack_pointer_high <= vui_pkg::SP_RESET;
			spl <= vui_pkg::SP_RESET;
			PUSH <= '0;
		end else begin
			PUSH.valid <= 1'b0;
			if (push_now && !push_fault) begin
				PUSH.valid <= 1'b1;
				PUSH.data <= push_byte;
				PUSH.ext <= ctrl[vui_pkg::CTRL_EXT_STACK_BIT];
				if (ctrl[vui_pkg::CTRL_EXT_STACK_BIT]) begin
					{stack_pointer_high, spl} <= sp_dec;
					PUSH.addr <= sp_dec;
				end else begin
					spl <= spl_dec;
					PUSH.addr <= {8'h00, spl_dec};
				end
			end else begin
				if (wr && idx == vui_pkg::IDX_SPH) begin
					stack_pointer_high <= PWDATA[7:0];
				end
				if (wr && idx == vui_pkg::IDX_SPL) begin
					spl <= PWDATA[7:0];
				end
			end
		end
	end

	// Vector fetch: high byte at slot base, low byte next
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			FETCH <= '0;
			fetch_hi_q <= 1'b0;
			fetch_lo_q <= 1'b0;
			vec <= vui_pkg::RESET_START;
		end else begin
			fetch_hi_q <= 1'b0;
			fetch_lo_q <= 1'b0;
			FETCH.valid <= 1'b0;
			if (state == vui_pkg::VUI_FETCH && cnt == vui_pkg::FETCH_HI_AT) begin
				FETCH.valid <= 1'b1;
				FETCH.addr <= {12'h000, grant, 1'b0};
				fetch_hi_q <= 1'b1;
			end
			if (state == vui_pkg::VUI_FETCH && cnt == vui_pkg::FETCH_LO_AT) begin
				FETCH.valid <= 1'b1;
				FETCH.addr <= {12'h000, grant, 1'b1};
				fetch_lo_q <= 1'b1;
			end
			if (fetch_hi_q) begin
				vec[15:8] <= VEC_DATA;
			end
			if (fetch_lo_q) begin
				vec[7:0] <= VEC_DATA;
			end
		end
	end

	// Jump on cycle 58 after the sample point
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			JUMP <= 1'b0;
			NEW_PC <= vui_pkg::RESET_START;
		end else begin
			JUMP <= (state == vui_pkg::VUI_FETCH) && (cnt == vui_pkg::FETCH_LAST);
			if ((state == vui_pkg::VUI_FETCH) && (cnt == vui_pkg::FETCH_LAST)) begin
				NEW_PC <= vec;
			end
		end
	end

	// Status events, write one to clear, set wins
	assign entry_done = (state == vui_pkg::VUI_FETCH) && (cnt == vui_pkg::FETCH_LAST);
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			evt <= 2'b00;
			INT_LINE <= 1'b0;
		end else begin
			logic [1:0] nxt;
			nxt = evt;
			if (wr && idx == vui_pkg::IDX_EVT) begin
				nxt = nxt & ~PWDATA[1:0];
			end
			nxt[vui_pkg::EVT_ENTRY_BIT] = nxt[vui_pkg::EVT_ENTRY_BIT] | entry_done;
			nxt[vui_pkg::EVT_FAULT_BIT] = nxt[vui_pkg::EVT_FAULT_BIT] |
				(push_now & push_fault);
			evt <= nxt;
			INT_LINE <= |(nxt & evt_mask);
		end
	end

	// Unused bits of the fetch constant width
	logic unused_fetch_cycles;
	assign unused_fetch_cycles = ^vui_pkg::FETCH_CYCLES;
endmodule // vui_top

// ===== verilog/vui_pkg.sv
// Constants and carrier types of the vectored interrupt unit
package vui_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_REQ = 10'h000;
	localparam logic [9:0] IDX_MASK = 10'h001;
	localparam logic [9:0] IDX_PRIO = 10'h002;
	localparam logic [9:0] IDX_CTRL = 10'h003;
	localparam logic [9:0] IDX_EVT = 10'h004;
	localparam logic [9:0] IDX_EVT_MASK = 10'h005;
	localparam logic [9:0] IDX_STATE = 10'h006;
	localparam logic [9:0] IDX_SPH = 10'h0FE;
	localparam logic [9:0] IDX_SPL = 10'h0FF;
	// Field positions
	localparam int MASK_GLOBAL_BIT = 7;
	localparam int CTRL_EXT_STACK_BIT = 0;
	localparam int CTRL_EXT_PROG_BIT = 1;
	localparam int PRIO_REVERSE_BIT = 3;
	localparam int EVT_ENTRY_BIT = 0;
	localparam int EVT_FAULT_BIT = 1;
	// Reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [3:0] PRIO_RESET = 4'h0;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [7:0] SP_RESET = 8'h00;
	localparam logic [15:0] RESET_START = 16'h000C;
	// Entry sequence timing, in clock periods after the sample point
	localparam int REQ_SETUP_PERIODS = 5;
	localparam logic [5:0] PUSH_LAST = 6'd48;
	localparam logic [5:0] FETCH_CYCLES = 6'd9;
	localparam logic [5:0] FETCH_LAST = 6'd57;
	localparam logic [5:0] PUSH_PCL_AT = 6'd16;
	localparam logic [5:0] PUSH_PCH_AT = 6'd32;
	localparam logic [5:0] PUSH_FLG_AT = 6'd48;
	localparam logic [5:0] FETCH_HI_AT = 6'd50;
	localparam logic [5:0] FETCH_LO_AT = 6'd54;
	// Stack limits
	localparam logic [15:0] EXT_STACK_FLOOR = 16'h4000;
	localparam logic [7:0] INT_STACK_LOW = 8'h04;
	localparam logic [7:0] INT_STACK_HIGH = 8'hEF;
	// Entry sequencer states, Gray along the path
	typedef enum logic [1:0] {
		VUI_IDLE = 2'b00,
		VUI_PUSH = 2'b01,
		VUI_FETCH = 2'b11,
		VUI_JUMP = 2'b10
	} vui_state_t;
	// One stack write toward memory or the register file
	typedef struct packed {
		logic valid;
		logic ext;
		logic [15:0] addr;
		logic [7:0] data;
	} vui_push_t;
	// One vector byte read from program memory
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} vui_fetch_t;
endpackage

// ===== verification/vui_monitor.sv
// Port checker for the vectored interrupt unit
`timescale 1ns/1ps
module vui_monitor (
	input wire logic CLK, // Clock
	input wire logic RSTN, // Reset, low
	input wire logic PSEL, // Select
	input wire logic PENABLE, // Access phase
	input wire logic PREADY, // Ready
	input wire logic PSLVERR, // Error
	input wire logic LAST_CYCLE, // Sample point
	input wire logic [15:0] PC_IN, // Counter to save
	input wire logic [7:0] FLAGS_IN, // Flags to save
	input wire vui_pkg::vui_push_t PUSH, // Stack write
	input wire vui_pkg::vui_fetch_t FETCH, // Vector read
	input wire logic JUMP, // Jump pulse
	input wire logic BUSY // Entry running
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// Bus answer after one wait state, one cycle long
	a_ready_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
		else $error("ready timing wrong");
	// Push sequence carries counter bytes then flags
	a_push_save_order: assert property ($rose(BUSY) |-> ##16 (PUSH.valid && PUSH.data == PC_IN[7:0])
		##16 (PUSH.valid && PUSH.data == PC_IN[15:8]) ##16 (PUSH.valid && PUSH.data == FLAGS_IN))
		else $error("push sequence wrong");
	// Vector reads and jump at fixed cycles
	a_fetch_then_jump: assert property ($rose(BUSY) |-> ##50 FETCH.valid ##4 FETCH.valid ##3 JUMP)
		else $error("fetch or jump cycle wrong");
	a_vector_pair: assert property (FETCH.valid && !FETCH.addr[0] |->
		##4 (FETCH.valid && FETCH.addr == $past(FETCH.addr, 4) + 16'h0001))
		else $error("vector bytes not paired");
	a_vector_area: assert property (FETCH.valid |-> FETCH.addr < 16'h000C)
		else $error("vector read outside table");
	a_grant_at_sample: assert property ($rose(BUSY) |-> $past(LAST_CYCLE))
		else $error("grant without sample point");
	a_jump_ends_busy: assert property (JUMP |-> BUSY ##1 !BUSY)
		else $error("busy not ended by jump");
	a_single_pulse: assert property (PUSH.valid || JUMP |=> !PUSH.valid && !JUMP)
		else $error("strobe longer than a cycle");
	a_int_stack_range: assert property (PUSH.valid && !PUSH.ext |->
		PUSH.addr[7:0] >= 8'h04 && PUSH.addr[7:0] <= 8'hEF)
		else $error("internal push out of range");
	// Main scenarios reached
	c_entry: cover property ($rose(BUSY));
	c_ext_push: cover property (PUSH.valid && PUSH.ext);
	c_unmapped: cover property (PSLVERR);
endmodule // vui_monitor
bind vui_top vui_monitor vui_monitor_i (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .LAST_CYCLE(LAST_CYCLE), .PC_IN(PC_IN),
	.FLAGS_IN(FLAGS_IN), .PUSH(PUSH), .FETCH(FETCH), .JUMP(JUMP), .BUSY(BUSY));

// ===== verification/vui_core_model.sv
// Program memory side of the core: answers vector reads
`timescale 1ns/1ps
module vui_core_model (
	input wire logic CLK, // Clock
	input wire vui_pkg::vui_fetch_t FETCH, // Vector read
	output logic [7:0] VEC_DATA // Program byte
);
	logic [7:0] stale = 8'h5A;
	// Idle byte toggles each cycle so a capture at the wrong time shows
	always @(posedge CLK) begin
		stale <= ~stale;
	end
	// Byte at address a holds A0 plus a, answered while the read strobe stands
	assign VEC_DATA = FETCH.valid ? 8'hA0 + FETCH.addr[7:0] : stale;
endmodule // vui_core_model

// ===== verification/vectored_interrupt_unit_tb_top.sv
// Self-checking testbench of the vectored interrupt unit
`timescale 1ns/1ps
module vectored_interrupt_unit_tb_top;
	logic CLK = 1'b0;
	logic RSTN = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic [3:0] EXT_REQ_PINS = 4'h0;
	logic SER_TX_REQ = 1'b0;
	logic SER_RX_REQ = 1'b0;
	logic [1:0] PRESCALE_END = 2'h0;
	logic [1:0] COUNT_END = 2'h0;
	logic LAST_CYCLE = 1'b0;
	logic [15:0] PC_IN = 16'h1234;
	logic [7:0] FLAGS_IN = 8'hC3;
	logic [7:0] VEC_DATA;
	vui_pkg::vui_push_t PUSH;
	vui_pkg::vui_fetch_t FETCH;
	logic JUMP;
	logic [15:0] NEW_PC;
	logic BUSY;
	logic INT_LINE;
	int num_errors = 0;
	int checked = 0;
	logic [31:0] rd;
	logic err;
	vui_top vui_top_i (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .EXT_REQ_PINS, .SER_TX_REQ, .SER_RX_REQ, .PRESCALE_END,
		.COUNT_END, .LAST_CYCLE, .PC_IN, .FLAGS_IN, .VEC_DATA, .PUSH, .FETCH, .JUMP,
		.NEW_PC, .BUSY, .INT_LINE);
	vui_core_model vui_core_model_i (.CLK, .FETCH, .VEC_DATA);
	// 100 ns clock
	always #50 CLK = ~CLK;
	// Verdict and end of run
	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Compare and count
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One bus transfer, held until ready is seen
	task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= {idx, 2'b00};
		PWDATA <= wd;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1 && n < 20) begin
			n++;
			@(posedge CLK);
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
		if (n == 20) begin
			num_errors++;
			print_verdict();
		end
	endtask
	// Read and compare
	task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		check(rd, exp);
	endtask
	// Sample point after the request has stood long enough
	task automatic pulse_sample();
		repeat (6) @(posedge CLK);
		LAST_CYCLE <= 1'b1;
		@(posedge CLK);
		LAST_CYCLE <= 1'b0;
	endtask
	// Entry: jump cycle and target
	task automatic take_entry(input logic [15:0] exp_pc);
		int n;
		n = 0;
		pulse_sample();
		while (JUMP !== 1'b1 && n < 80) begin
			@(posedge CLK);
			n++;
		end
		check(32'(n), 32'd58);
		check({16'h0, NEW_PC}, {16'h0, exp_pc});
		repeat (2) @(posedge CLK);
		if (n == 80) begin
			print_verdict();
		end
	endtask
	// Reset values and unmapped place
	task automatic t_reset_values();
		check({16'h0, NEW_PC}, 32'h000C);
		rd_chk(vui_pkg::IDX_MASK, 32'h0);
		rd_chk(vui_pkg::IDX_PRIO, 32'h0);
		rd_chk(vui_pkg::IDX_SPL, 32'h0);
		apb(1'b0, 10'h010, 32'h0);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
	endtask
	// Sources latch while masked, counters need both ends
	task automatic t_polled();
		PRESCALE_END <= 2'b11;
		pulse_sample();
		check({31'h0, BUSY}, 32'h0);
		rd_chk(vui_pkg::IDX_REQ, 32'h0);
		COUNT_END <= 2'b11;
		@(posedge CLK);
		rd_chk(vui_pkg::IDX_REQ, 32'h30);
		EXT_REQ_PINS <= 4'hF;
		SER_TX_REQ <= 1'b1;
		SER_RX_REQ <= 1'b1;
		@(posedge CLK);
		rd_chk(vui_pkg::IDX_REQ, 32'h3F);
		apb(1'b1, vui_pkg::IDX_REQ, 32'h0);
	endtask
	// Software request, masking, internal stack, event interrupt
	task automatic t_entry_internal();
		apb(1'b1, vui_pkg::IDX_SPH, 32'h55);
		apb(1'b1, vui_pkg::IDX_SPL, 32'h20);
		apb(1'b1, vui_pkg::IDX_MASK, 32'h9F);
		apb(1'b1, vui_pkg::IDX_REQ, 32'h20);
		pulse_sample();
		repeat (3) @(posedge CLK);
		check({31'h0, BUSY}, 32'h0);
		apb(1'b1, vui_pkg::IDX_REQ, 32'h24);
		apb(1'b1, vui_pkg::IDX_MASK, 32'hBF);
		take_entry(16'hA4A5);
		rd_chk(vui_pkg::IDX_REQ, 32'h20);
		rd_chk(vui_pkg::IDX_MASK, 32'h3F);
		rd_chk(vui_pkg::IDX_SPL, 32'h1D);
		rd_chk(vui_pkg::IDX_SPH, 32'h55);
		rd_chk(vui_pkg::IDX_EVT, 32'h1);
		check({31'h0, INT_LINE}, 32'h0);
		apb(1'b1, vui_pkg::IDX_EVT_MASK, 32'h1);
		check({31'h0, INT_LINE}, 32'h1);
		apb(1'b1, vui_pkg::IDX_EVT, 32'h1);
		check({31'h0, INT_LINE}, 32'h0);
	endtask
	// Reversed priority from a start index, external stack below the floor
	task automatic t_entry_external();
		apb(1'b1, vui_pkg::IDX_CTRL, 32'h3);
		apb(1'b1, vui_pkg::IDX_SPH, 32'h40);
		apb(1'b1, vui_pkg::IDX_SPL, 32'h01);
		apb(1'b1, vui_pkg::IDX_PRIO, 32'hB);
		apb(1'b1, vui_pkg::IDX_REQ, 32'h22);
		apb(1'b1, vui_pkg::IDX_MASK, 32'hBF);
		take_entry(16'hA2A3);
		rd_chk(vui_pkg::IDX_SPH, 32'h3F);
		rd_chk(vui_pkg::IDX_SPL, 32'hFE);
		rd_chk(vui_pkg::IDX_REQ, 32'h20);
		rd_chk(vui_pkg::IDX_STATE, 32'h1);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (3) @(posedge CLK);
		t_reset_values();
		t_polled();
		t_entry_internal();
		t_entry_external();
		print_verdict();
	end
endmodule // vectored_interrupt_unit_tb_top
